// ### rtl/acq_consts.svh
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH

// acquisition memory depth in record points per channel
`define ACQ_MEM_POINTS 16'd1024
`define ACQ_MEM_HALF 16'd512
`define ACQ_MEM_AW 10
// digitizer resolution and the ceiling for interval averaging
`define ACQ_BASE_BITS 4'd8
`define ACQ_MAX_BITS 4'd15
`define ACQ_MAX_EXTRA 5'd7
// reset values
`define ACQ_COUNT_RST 16'h0000
`define ACQ_LEN_RST 16'h0001
`define ACQ_SPAN_RST 24'h000001
`define ACQ_TARGET_RST 16'h0001

`endif

// ### rtl/acq_decimator.sv
`timescale 1ns/1ns
`include "acq_consts.svh"

module acq_decimator (
    input wire logic clock, // 20 MHz system clock
    input wire logic rst, // synchronous reset, high
    input wire logic sample_valid, // digitizer sample strobe
    input wire logic [7:0] sample_data, // digitizer sample
    input wire logic trigger, // trigger event pulse
    input wire logic [2:0] mode_sel, // requested acquisition mode
    input wire logic fast_capture, // fast waveform capture active
    input wire logic equivalent_time_or_interpolated, // time base not realtime
    input wire logic timebase_slow, // time base slower than 100 ns/div
    input wire logic [15:0] record_len, // record length in points
    input wire logic [23:0] record_span, // record span in samples
    input wire logic [15:0] acq_target, // acquisitions to combine
    input wire logic single_seq, // stop after one sequence
    input wire logic run_start, // start acquiring pulse
    input wire logic run_stop, // stop acquiring pulse
    output logic point_valid, // record point strobe
    output logic [15:0] point_index, // record point address
    output logic [14:0] point_data, // record point value
    output logic [3:0] point_bits, // significant bits of point
    output logic record_done, // record complete pulse
    output logic result_complete, // combined result complete pulse
    output logic running, // acquisition running
    output logic [15:0] acq_count, // acquisitions since run start or change
    output logic [15:0] eff_record_len, // record length in use
    output logic [2:0] mode_effective, // mode actually processed
    output logic mode_refused // selected mode blocked by fast capture
);

    acq_pkg::acq_mode_e mode_r;
    acq_pkg::acq_state_e state_r;
    logic [15:0] len_r;
    logic [23:0] span_r;
    logic [15:0] target_r;
    logic [23:0] sidx_r;
    logic [15:0] pidx_r;
    logic [7:0] first_r, max_r, min_r;
    logic [31:0] sum_r;
    logic [15:0] acq_total_r;
    logic [15:0] combine_idx_r;
    logic [14:0] mem [0:`ACQ_MEM_POINTS-1];
    logic point_valid_r, record_done_r, complete_r;
    logic [15:0] point_index_r;
    logic [14:0] point_data_r;
    logic [3:0] point_bits_r;

    function automatic logic [4:0] acq_log2(input logic [23:0] v);
        logic [4:0] r;
        r = 5'd0;
        for (int i = 0; i < 24; i++) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic acq_pkg::acq_mode_e acq_decode(input logic [2:0] m);
        acq_pkg::acq_mode_e r;
        r = acq_pkg::ACQ_SAMPLE;
        if (m == 3'h1) begin
            r = acq_pkg::ACQ_PEAK;
        end else if (m == 3'h2) begin
            r = acq_pkg::ACQ_IAVG;
        end else if (m == 3'h3) begin
            r = acq_pkg::ACQ_ENV;
        end else if (m == 3'h4) begin
            r = acq_pkg::ACQ_MAVG;
        end
        return r;
    endfunction

    // configuration and mode selection
    wire acq_pkg::acq_mode_e mode_in = acq_decode(mode_sel);
    wire cfg_change = (mode_in != mode_r) || (record_len != len_r)
        || (record_span != span_r) || (acq_target != target_r);
    wire needs_full = (mode_r == acq_pkg::ACQ_IAVG) || (mode_r == acq_pkg::ACQ_ENV)
        || (mode_r == acq_pkg::ACQ_MAVG);
    wire refused = fast_capture && needs_full;
    wire realtime_only = (mode_r == acq_pkg::ACQ_PEAK) || (mode_r == acq_pkg::ACQ_IAVG);
    wire fallback = equivalent_time_or_interpolated && realtime_only;
    // menu selection mode_r stays put; only processing changes
    wire acq_pkg::acq_mode_e proc_mode = (refused || fallback) ? acq_pkg::ACQ_SAMPLE : mode_r;
    wire multi = (proc_mode == acq_pkg::ACQ_ENV) || (proc_mode == acq_pkg::ACQ_MAVG);

    // interval average stores twice the data, so only half the points fit
    wire [15:0] len_limit = (mode_r == acq_pkg::ACQ_IAVG) ? `ACQ_MEM_HALF
        : `ACQ_MEM_POINTS;
    wire [15:0] len_nz = (len_r == 16'h0000) ? 16'h0001 : len_r;
    wire [15:0] eff_len = (len_nz > len_limit) ? len_limit : len_nz;
    wire [23:0] interval_raw = span_r / {8'h00, eff_len};
    wire [23:0] interval = (interval_raw == 24'h0) ? 24'h1 : interval_raw;

    // per-interval gathering
    wire take = (state_r == acq_pkg::ACQ_ST_FILL) && sample_valid;
    wire s_first = (sidx_r == 24'h0);
    wire s_last = (sidx_r == interval - 24'h1);
    wire p_last = (pidx_r == eff_len - 16'h1);
    wire rec_end = take && s_last && p_last;
    wire [7:0] cur_first = s_first ? sample_data : first_r;
    wire [7:0] cur_max = (s_first || sample_data > max_r) ? sample_data : max_r;
    wire [7:0] cur_min = (s_first || sample_data < min_r) ? sample_data : min_r;
    wire [31:0] cur_sum = s_first ? {24'h0, sample_data} : sum_r + {24'h0, sample_data};
    wire pt_even = ~pidx_r[0];

    // resolution gain is half the log2 of samples per interval, capped at 7 bits, and zero unless timebase_slow
    wire [4:0] log_span = acq_log2(interval);
    wire [4:0] half_log = {1'b0, log_span[4:1]};
    wire [4:0] extra_cap = (half_log > `ACQ_MAX_EXTRA) ? `ACQ_MAX_EXTRA : half_log;
    wire [4:0] extra = timebase_slow ? extra_cap : 5'd0;
    wire [39:0] sum_scaled = {8'h00, cur_sum} << extra;
    wire [39:0] mean_full = sum_scaled / {16'h0000, interval};
    wire [14:0] hires = mean_full[14:0];
    wire [3:0] bits_iavg = `ACQ_BASE_BITS + 4'(extra);

    wire [7:0] peak_val = pt_even ? cur_max : cur_min;
    wire [14:0] new_pt = (proc_mode == acq_pkg::ACQ_IAVG) ? hires
        : ((proc_mode == acq_pkg::ACQ_PEAK) || (proc_mode == acq_pkg::ACQ_ENV))
        ? {7'h00, peak_val} : {7'h00, cur_first};
    wire [3:0] new_bits = (proc_mode == acq_pkg::ACQ_IAVG) ? bits_iavg : `ACQ_BASE_BITS;

    // combining with stored acquisitions
    wire [`ACQ_MEM_AW-1:0] maddr = pidx_r[`ACQ_MEM_AW-1:0];
    wire [14:0] stored = mem[maddr];
    wire fresh = (combine_idx_r == 16'h0);
    wire [14:0] env_val = pt_even ? ((new_pt > stored) ? new_pt : stored)
        : ((new_pt < stored) ? new_pt : stored);
    wire signed [16:0] avg_diff = $signed({2'b00, new_pt}) - $signed({2'b00, stored});
    wire signed [17:0] avg_div = $signed({2'b00, combine_idx_r} + 18'sd1);
    wire signed [17:0] avg_step = 18'(avg_diff) / avg_div;
    wire [17:0] avg_sum = 18'($signed({3'b000, stored}) + avg_step);
    wire [14:0] avg_val = avg_sum[14:0];
    wire [14:0] comb_pt = (!multi || fresh) ? new_pt
        : (proc_mode == acq_pkg::ACQ_ENV) ? env_val : avg_val;

    wire [15:0] target_nz = (target_r == 16'h0) ? 16'h0001 : target_r;
    wire comb_full = (combine_idx_r + 16'h1) >= target_nz;
    wire seq_done = !multi || comb_full;
    wire stop_now = rec_end && single_seq && seq_done;

    // mode register follows the selection; any difference is a major change
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_r <= acq_pkg::ACQ_SAMPLE;
            len_r <= `ACQ_LEN_RST;
            span_r <= `ACQ_SPAN_RST;
            target_r <= `ACQ_TARGET_RST;
        end else begin
            mode_r <= mode_in;
            len_r <= record_len;
            span_r <= record_span;
            target_r <= acq_target;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= acq_pkg::ACQ_ST_STOP;
        end else begin
            case (state_r)
                acq_pkg::ACQ_ST_STOP: begin
                    if (run_start) begin
                        state_r <= acq_pkg::ACQ_ST_ARM;
                    end
                end
                acq_pkg::ACQ_ST_ARM: begin
                    if (run_stop) begin
                        state_r <= acq_pkg::ACQ_ST_STOP;
                    end else if (trigger && !cfg_change) begin
                        state_r <= acq_pkg::ACQ_ST_FILL;
                    end
                end
                acq_pkg::ACQ_ST_FILL: begin
                    if (run_stop || stop_now) begin
                        state_r <= acq_pkg::ACQ_ST_STOP;
                    end else if (rec_end || cfg_change) begin
                        state_r <= acq_pkg::ACQ_ST_ARM;
                    end
                end
                default: begin
                    state_r <= acq_pkg::ACQ_ST_STOP;
                end
            endcase
        end
    end

    // position within interval and record
    always_ff @(posedge clock) begin
        if (rst || state_r != acq_pkg::ACQ_ST_FILL || cfg_change) begin
            sidx_r <= 24'h0;
            pidx_r <= 16'h0;
        end else if (take) begin
            sidx_r <= s_last ? 24'h0 : sidx_r + 24'h1;
            pidx_r <= !s_last ? pidx_r : (p_last ? 16'h0 : pidx_r + 16'h1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            first_r <= 8'h00;
            max_r <= 8'h00;
            min_r <= 8'h00;
            sum_r <= 32'h0;
        end else if (take) begin
            first_r <= cur_first;
            max_r <= cur_max;
            min_r <= cur_min;
            sum_r <= cur_sum;
        end
    end

    // stored array only carries data between acquisitions of one combine
    always_ff @(posedge clock) begin
        if (take && s_last && multi) begin
            mem[maddr] <= comb_pt;
        end
    end

    // restart after stop or config change begins a fresh combine
    always_ff @(posedge clock) begin
        if (rst || cfg_change || (state_r == acq_pkg::ACQ_ST_STOP && run_start)) begin
            acq_total_r <= `ACQ_COUNT_RST;
            combine_idx_r <= 16'h0;
        end else if (rec_end) begin
            if (acq_total_r != 16'hffff) begin
                acq_total_r <= acq_total_r + 16'h1;
            end
            combine_idx_r <= (!multi || comb_full) ? 16'h0 : combine_idx_r + 16'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            point_valid_r <= 1'b0;
            point_index_r <= 16'h0;
            point_data_r <= 15'h0;
            point_bits_r <= `ACQ_BASE_BITS;
            record_done_r <= 1'b0;
            complete_r <= 1'b0;
        end else begin
            point_valid_r <= take && s_last;
            record_done_r <= rec_end;
            complete_r <= rec_end && seq_done;
            if (take && s_last) begin
                point_index_r <= pidx_r;
                point_data_r <= comb_pt;
                point_bits_r <= new_bits;
            end
        end
    end

    assign point_valid = point_valid_r;
    assign point_index = point_index_r;
    assign point_data = point_data_r;
    assign point_bits = point_bits_r;
    assign record_done = record_done_r;
    assign result_complete = complete_r;
    assign running = (state_r != acq_pkg::ACQ_ST_STOP);
    assign acq_count = acq_total_r;
    assign eff_record_len = eff_len;
    assign mode_effective = proc_mode;
    assign mode_refused = refused;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // own disable, since the default one would switch this check off
    property p_default_mode;
        disable iff (1'b0) rst |=> mode_effective == 3'b000;
    endproperty
    a_default_mode: assert property (p_default_mode) else $error("mode not sample after reset");

    property p_peak_fallback;
        mode_r == acq_pkg::ACQ_PEAK && equivalent_time_or_interpolated
            |-> mode_effective == 3'b000 && !mode_refused;
    endproperty
    a_peak_fallback: assert property (p_peak_fallback) else $error("peak did not fall back");

    property p_iavg_fallback;
        mode_sel == 3'h2 && $past(mode_sel) == 3'h2 && equivalent_time_or_interpolated
            |-> mode_effective == 3'b000;
    endproperty
    a_iavg_fallback: assert property (p_iavg_fallback) else $error("average did not fall back");

    property p_fast_refuse;
        fast_capture && mode_sel == 3'h3 && $past(mode_sel) == 3'h3 && !$past(rst)
            |-> mode_refused && mode_effective == 3'b000;
    endproperty
    a_fast_refuse: assert property (p_fast_refuse) else $error("envelope ran in fast capture");

    property p_len_half;
        mode_r == acq_pkg::ACQ_IAVG |-> eff_record_len <= `ACQ_MEM_HALF && eff_record_len != 16'h0;
    endproperty
    a_len_half: assert property (p_len_half) else $error("record too long for average");

    property p_bits_cap;
        point_valid |-> point_bits <= `ACQ_MAX_BITS && point_bits >= `ACQ_BASE_BITS;
    endproperty
    a_bits_cap: assert property (p_bits_cap) else $error("resolution out of range");

    property p_fast_base_bits;
        take && s_last && !timebase_slow |=> point_valid && point_bits == `ACQ_BASE_BITS;
    endproperty
    a_fast_base_bits: assert property (p_fast_base_bits) else $error("extra bits at fast base");

    property p_first_sample;
        take && s_last && !s_first && proc_mode == acq_pkg::ACQ_SAMPLE
            |=> point_valid && point_data == {7'h00, $past(first_r)};
    endproperty
    a_first_sample: assert property (p_first_sample) else $error("sample not first");

    property p_count_up;
        rec_end && !cfg_change && acq_total_r != 16'hffff |=> acq_count == $past(acq_count) + 16'h1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("acquisition count missed");

    property p_single_stop;
        rec_end && single_seq && !multi && !cfg_change
            |=> !running ##1 (!running || $past(run_start));
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single sequence kept running");

    property p_restart_clear;
        !running && run_start |=> acq_count == 16'h0 && combine_idx_r == 16'h0;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("restart kept old data");

endmodule

// ### rtl/acq_pkg.sv
package acq_pkg;

    typedef enum logic [2:0] {
        ACQ_SAMPLE = 3'b000,
        ACQ_PEAK = 3'b001,
        ACQ_IAVG = 3'b010,
        ACQ_ENV = 3'b011,
        ACQ_MAVG = 3'b100
    } acq_mode_e;

    typedef enum logic [1:0] {
        ACQ_ST_STOP = 2'b00,
        ACQ_ST_ARM = 2'b01,
        ACQ_ST_FILL = 2'b10
    } acq_state_e;

endpackage

// ### verification/acq_digitizer_model.sv
`timescale 1ns/1ns
module acq_digitizer_model (
    input wire logic clock, // sample clock
    input wire logic play, // emit one sample per cycle
    output logic sample_valid, // sample strobe
    output logic [7:0] sample_data // sample value
);
    logic [7:0] seq [0:7];
    logic [2:0] pos_r;
    logic [7:0] last_r;
    initial begin
        pos_r = 3'h0;
        last_r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            seq[i] = 8'h00;
        end
    end
    // idle stream shows inverted last value so stale data never passes for a sample
    assign sample_valid = play;
    assign sample_data = play ? seq[pos_r] : ~last_r;
    always @(posedge clock) begin
        if (play) begin
            pos_r <= pos_r + 3'h1;
            last_r <= seq[pos_r];
        end else begin
            pos_r <= 3'h0;
        end
    end
endmodule

// ### verification/acquisition_mode_decimator_test.sv
`timescale 1ns/1ns
`include "acq_consts.svh"
module acquisition_mode_decimator_test;
    localparam int LIMIT = 5000;
    logic clock, rst, play, trigger, fast_capture, equivalent_time_or_interpolated;
    logic timebase_slow, single_seq, run_start, run_stop, sample_valid;
    logic point_valid, record_done, result_complete, running, mode_refused;
    logic [7:0] sample_data;
    logic [2:0] mode_sel, mode_effective;
    logic [15:0] record_len, acq_target, point_index, acq_count, eff_record_len;
    logic [23:0] record_span;
    logic [14:0] point_data;
    logic [3:0] point_bits, bits_seen;
    logic [15:0] pts[$];
    logic [15:0] idx[$];
    int n_fail = 0, n_compared = 0, n_done = 0, n_result = 0, cycles = 0;

    acq_digitizer_model part_u (.clock, .play, .sample_valid, .sample_data);
    acq_decimator dut_u (.clock, .rst, .sample_valid, .sample_data, .trigger, .mode_sel,
        .fast_capture, .equivalent_time_or_interpolated, .timebase_slow, .record_len,
        .record_span, .acq_target, .single_seq, .run_start, .run_stop, .point_valid,
        .point_index, .point_data, .point_bits, .record_done, .result_complete, .running,
        .acq_count, .eff_record_len, .mode_effective, .mode_refused);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // pre-edge values are the ones standing in that cycle
    always @(posedge clock) begin
        if (point_valid === 1'b1) begin
            pts.push_back({1'b0, point_data});
            idx.push_back(point_index);
            bits_seen <= point_bits;
        end
        if (record_done === 1'b1) n_done++;
        if (result_complete === 1'b1) n_result++;
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #5;
        end
    endtask

    // config only changes while stopped; a change mid-record would abort it
    task automatic configure(input logic [2:0] m, input logic [15:0] len,
            input logic [23:0] span, input logic [15:0] tgt);
        run_stop = 1'b1;
        tick(1);
        run_stop = 1'b0;
        mode_sel = m;
        record_len = len;
        record_span = span;
        acq_target = tgt;
        tick(3);
        run_start = 1'b1;
        tick(1);
        run_start = 1'b0;
        tick(1);
        pts.delete();
        idx.delete();
        n_done = 0;
        n_result = 0;
    endtask

    task automatic acquire(input logic [7:0] s [0:7], input int n);
        part_u.seq = s;
        trigger = 1'b1;
        tick(1);
        trigger = 1'b0;
        play = 1'b1;
        tick(n);
        play = 1'b0;
        tick(3);
    endtask

    task automatic check_pair(input logic [15:0] a, input logic [15:0] b, input int base);
        check("point a", a, pts[base]);
        check("point b", b, pts[base + 1]);
        check("index a", 16'h0000, idx[base]);
        check("index b", 16'h0001, idx[base + 1]);
    endtask

    task automatic t_reset();
        check("mode_effective", 16'h0000, {13'h0, mode_effective});
        check("acq_count", 16'h0000, acq_count);
        check("point_bits", 16'h0008, {12'h0, point_bits});
        $display("test reset done");
    endtask

    task automatic t_sample();
        configure(acq_pkg::ACQ_SAMPLE, 16'h0002, 24'h000004, 16'h0001);
        check("running", 16'h0001, {15'h0, running});
        acquire('{8'h0a, 8'h14, 8'h1e, 8'h28, 8'h0, 8'h0, 8'h0, 8'h0}, 4);
        check_pair(16'h000a, 16'h001e, 0);
        check("records", 16'h0001, 16'(n_done));
        run_stop = 1'b1;
        tick(1);
        run_stop = 1'b0;
        tick(2);
        check("stopped count", 16'h0001, acq_count);
        $display("test sample done");
    endtask

    task automatic t_peak(input logic et);
        equivalent_time_or_interpolated = et;
        configure(acq_pkg::ACQ_PEAK, 16'h0002, 24'h000004, 16'h0001);
        check("mode_effective", et ? 16'h0000 : 16'h0001, {13'h0, mode_effective});
        acquire('{8'h0a, 8'h32, 8'h46, 8'h05, 8'h0, 8'h0, 8'h0, 8'h0}, 4);
        if (et) check_pair(16'h000a, 16'h0046, 0);
        else check_pair(16'h0032, 16'h0005, 0);
        equivalent_time_or_interpolated = 1'b0;
        $display("test peak done");
    endtask

    task automatic t_iavg(input logic slow);
        timebase_slow = slow;
        configure(acq_pkg::ACQ_IAVG, 16'h07d0, 24'h000008, 16'h0001);
        check("eff_record_len", `ACQ_MEM_HALF, eff_record_len);
        configure(acq_pkg::ACQ_IAVG, 16'h0002, 24'h000008, 16'h0001);
        acquire('{8'h0a, 8'h14, 8'h1e, 8'h28, 8'h01, 8'h03, 8'h05, 8'h07}, 8);
        if (slow) check_pair(16'h0032, 16'h0008, 0);
        else check_pair(16'h0019, 16'h0004, 0);
        check("bits", slow ? 16'h0009 : 16'h0008, {12'h0, bits_seen});
        timebase_slow = 1'b0;
        $display("test interval average done");
    endtask

    task automatic t_refuse();
        fast_capture = 1'b1;
        configure(acq_pkg::ACQ_ENV, 16'h0002, 24'h000004, 16'h0001);
        check("mode_refused", 16'h0001, {15'h0, mode_refused});
        check("mode_effective", 16'h0000, {13'h0, mode_effective});
        fast_capture = 1'b0;
        tick(2);
        check("mode_refused", 16'h0000, {15'h0, mode_refused});
        // unused codes must act as plain sample mode
        mode_sel = 3'h5;
        tick(2);
        check("mode_effective", 16'h0000, {13'h0, mode_effective});
        $display("test fast capture done");
    endtask

    task automatic t_env();
        single_seq = 1'b1;
        configure(acq_pkg::ACQ_ENV, 16'h0002, 24'h000004, 16'h0002);
        acquire('{8'h0a, 8'h32, 8'h46, 8'h05, 8'h0, 8'h0, 8'h0, 8'h0}, 4);
        check("running", 16'h0001, {15'h0, running});
        acquire('{8'h3c, 8'h14, 8'h50, 8'h09, 8'h0, 8'h0, 8'h0, 8'h0}, 4);
        check_pair(16'h0032, 16'h0005, 0);
        check_pair(16'h003c, 16'h0005, 2);
        check("results", 16'h0001, 16'(n_result));
        check("running", 16'h0000, {15'h0, running});
        check("acq_count", 16'h0002, acq_count);
        single_seq = 1'b0;
        $display("test envelope done");
    endtask

    task automatic t_mavg();
        configure(acq_pkg::ACQ_MAVG, 16'h0002, 24'h000004, 16'h0002);
        acquire('{8'h0a, 8'h14, 8'h1e, 8'h28, 8'h0, 8'h0, 8'h0, 8'h0}, 4);
        acquire('{8'h32, 8'h00, 8'h06, 8'h00, 8'h0, 8'h0, 8'h0, 8'h0}, 4);
        check_pair(16'h000a, 16'h001e, 0);
        check_pair(16'h001e, 16'h0012, 2);
        check("results", 16'h0001, 16'(n_result));
        $display("test multi average done");
    endtask

    initial begin
        {rst, play, trigger, fast_capture, equivalent_time_or_interpolated} = 5'h10;
        {timebase_slow, single_seq, run_start, run_stop} = 4'h0;
        mode_sel = 3'h0;
        record_len = 16'h0002;
        record_span = 24'h000004;
        acq_target = 16'h0001;
        tick(4);
        rst = 1'b0;
        tick(1);
        t_reset();
        t_sample();
        t_peak(1'b0);
        t_peak(1'b1);
        t_iavg(1'b1);
        t_iavg(1'b0);
        t_refuse();
        t_env();
        t_mavg();
        end_of_test();
    end
endmodule
